//--- hdl/smp_pin_mux.sv
`timescale 1ns/10ps
// How it works
// - SD: pins 10-13 data, pin 08 command, pin 09 clock output.
// - Stick: data on pin 10, pins 11-13 added for four-bit operation.
// - Stick: bus state output on pin 08, card clock output on pin 09.
// - Stick clock from pin 07 external clock or internal clock; pin may be grounded.
// - NAND: eight-bit data on pins 10-17, bit 0 on pin 10.
// - NAND: command latch on pin 18, address latch on pin 19.
// - NAND: write strobe pin 08, read strobe pin 09, chip enable pin 02, all low-active.
// - NAND card present only when pins 00 and 01 are both low.
// - Pin 03 low means NAND card busy, high means ready.
// - SD: detect low-active on pin 00, write protect read from pin 03.
// - Stick detect is low-active on pin 01.
// - Pin 04 is the card supply control for every card type.
// - SD low-voltage supply control on pin 05 is left inactive.
// - Pin 06 is a low-active activity indicator for the selected card.
// - Pin 07 is ignored in SD mode; board grounds it.
// - NAND: pin 05 carries the card write-protect signal.
module smp_pin_mux (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Card type selection
    input wire smp_pkg::smp_mode_e mode_req,
    output smp_pkg::smp_mode_e mode_active,
    // Shared pin bank
    input wire logic [19:0] pin_in,
    output logic [19:0] pin_out,
    output logic [19:0] pin_oe_n,
    // SD controller side
    input wire logic [3:0] sd_data_out,
    input wire logic sd_data_oe,
    output logic [3:0] sd_data_in,
    input wire logic sd_cmd_out,
    input wire logic sd_cmd_oe,
    output logic sd_cmd_in,
    input wire logic sd_clk,
    input wire logic sd_supply_on,
    input wire logic sd_active,
    output logic sd_card_present,
    output logic sd_write_protected,
    // Stick controller side
    input wire logic [3:0] stick_data_out,
    input wire logic stick_data_oe,
    input wire logic stick_wide,
    output logic [3:0] stick_data_in,
    input wire logic stick_bus_state,
    input wire logic stick_clk,
    input wire logic stick_ext_clk_sel,
    input wire logic stick_supply_on,
    input wire logic stick_active,
    output logic stick_card_present,
    // NAND controller side
    input wire logic [7:0] nand_data_out,
    input wire logic nand_data_oe,
    output logic [7:0] nand_data_in,
    input wire logic nand_cmd_latch,
    input wire logic nand_addr_latch,
    input wire logic nand_write_strobe_n,
    input wire logic nand_read_strobe_n,
    input wire logic nand_chip_enable_n,
    input wire logic nand_supply_on,
    input wire logic nand_active,
    output logic nand_card_present,
    output logic nand_ready,
    output logic nand_write_protected
);
    import smp_pkg::*;

    smp_mode_e mode_q, mode_d;
    logic [19:0] pin_out_q, pin_out_d;
    logic [19:0] pin_oe_n_q, pin_oe_n_d;
    logic [3:0] sd_data_in_q, sd_data_in_d;
    logic sd_cmd_in_q, sd_cmd_in_d;
    logic sd_present_q, sd_present_d;
    logic sd_wp_q, sd_wp_d;
    logic [3:0] stick_data_in_q, stick_data_in_d;
    logic stick_present_q, stick_present_d;
    logic [7:0] nand_data_in_q, nand_data_in_d;
    logic nand_present_q, nand_present_d;
    logic nand_ready_q, nand_ready_d;
    logic nand_wp_q, nand_wp_d;
    logic mode_req_valid;

    // A request is honoured only for a real card type.
    assign mode_req_valid = (mode_req == SMP_MODE_SD) || (mode_req == SMP_MODE_STICK) ||
                            (mode_req == SMP_MODE_NAND);

    // Every change of card type passes through one released cycle, so two types never fight on a pin.
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            SMP_MODE_NONE: begin
                if (mode_req_valid) begin
                    mode_d = mode_req;
                end
            end
            default: begin
                if (mode_req != mode_q) begin
                    mode_d = SMP_MODE_NONE;
                end
            end
        endcase
    end

    // Mode register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= SMP_MODE_NONE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Pin drive follows the mode held now; pins 00, 01, 03 and 07 are never driven.
    always_comb begin
        pin_out_d = PIN_OUT_RESET;
        pin_oe_n_d = PIN_OE_N_RESET;
        case (mode_q)
            SMP_MODE_SD: begin
                pin_out_d[PIN_DATA_LO +: SD_DATA_W] = sd_data_out;
                pin_oe_n_d[PIN_DATA_LO +: SD_DATA_W] = {SD_DATA_W{~sd_data_oe}};
                pin_out_d[PIN_CMD_STROBE] = sd_cmd_out;
                pin_oe_n_d[PIN_CMD_STROBE] = ~sd_cmd_oe;
                pin_out_d[PIN_CLOCK_READ] = sd_clk;
                pin_oe_n_d[PIN_CLOCK_READ] = 1'b0;
                pin_out_d[PIN_SUPPLY] = sd_supply_on;
                pin_oe_n_d[PIN_SUPPLY] = 1'b0;
                pin_out_d[PIN_LED] = ~sd_active;
                pin_oe_n_d[PIN_LED] = 1'b0;
                // The low-voltage supply pin stays released; pin 07 is not looked at.
                pin_oe_n_d[PIN_LOW_VOLT_WP] = 1'b1;
            end
            SMP_MODE_STICK: begin
                pin_out_d[PIN_DATA_LO +: STICK_DATA_W] = stick_data_out;
                pin_oe_n_d[PIN_DATA_LO] = ~stick_data_oe;
                pin_oe_n_d[PIN_DATA_LO + 1 +: 3] = {3{~(stick_data_oe & stick_wide)}};
                pin_out_d[PIN_CMD_STROBE] = stick_bus_state;
                pin_oe_n_d[PIN_CMD_STROBE] = 1'b0;
                // External clock is sampled, so only clocks well below clk_sys/2 pass cleanly.
                pin_out_d[PIN_CLOCK_READ] = stick_ext_clk_sel ? pin_in[PIN_EXT_CLOCK] : stick_clk;
                pin_oe_n_d[PIN_CLOCK_READ] = 1'b0;
                pin_out_d[PIN_SUPPLY] = stick_supply_on;
                pin_oe_n_d[PIN_SUPPLY] = 1'b0;
                pin_out_d[PIN_LED] = ~stick_active;
                pin_oe_n_d[PIN_LED] = 1'b0;
            end
            SMP_MODE_NAND: begin
                pin_out_d[PIN_DATA_LO +: NAND_DATA_W] = nand_data_out;
                pin_oe_n_d[PIN_DATA_LO +: NAND_DATA_W] = {NAND_DATA_W{~nand_data_oe}};
                pin_out_d[PIN_CMD_LATCH] = nand_cmd_latch;
                pin_oe_n_d[PIN_CMD_LATCH] = 1'b0;
                pin_out_d[PIN_ADDR_LATCH] = nand_addr_latch;
                pin_oe_n_d[PIN_ADDR_LATCH] = 1'b0;
                pin_out_d[PIN_CMD_STROBE] = nand_write_strobe_n;
                pin_oe_n_d[PIN_CMD_STROBE] = 1'b0;
                pin_out_d[PIN_CLOCK_READ] = nand_read_strobe_n;
                pin_oe_n_d[PIN_CLOCK_READ] = 1'b0;
                pin_out_d[PIN_CHIP_ENABLE] = nand_chip_enable_n;
                pin_oe_n_d[PIN_CHIP_ENABLE] = 1'b0;
                pin_out_d[PIN_SUPPLY] = nand_supply_on;
                pin_oe_n_d[PIN_SUPPLY] = 1'b0;
                pin_out_d[PIN_LED] = ~nand_active;
                pin_oe_n_d[PIN_LED] = 1'b0;
            end
            default: begin
                pin_out_d = PIN_OUT_RESET;
            end
        endcase
    end

    // Pin drive registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_q <= PIN_OUT_RESET;
            pin_oe_n_q <= PIN_OE_N_RESET;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // Return path: sensed pin levels for each controller, gated so an unselected type sees idle data.
    always_comb begin
        sd_data_in_d = (mode_q == SMP_MODE_SD) ? pin_in[PIN_DATA_LO +: SD_DATA_W] : 4'h0;
        sd_cmd_in_d = (mode_q == SMP_MODE_SD) ? pin_in[PIN_CMD_STROBE] : 1'b0;
        sd_present_d = ~pin_in[PIN_DETECT_A];
        sd_wp_d = ~pin_in[PIN_WP_READY];
        stick_data_in_d = (mode_q == SMP_MODE_STICK) ? pin_in[PIN_DATA_LO +: STICK_DATA_W] : 4'h0;
        stick_present_d = ~pin_in[PIN_DETECT_B];
        nand_data_in_d = (mode_q == SMP_MODE_NAND) ? pin_in[PIN_DATA_LO +: NAND_DATA_W] : 8'h00;
        nand_present_d = ~pin_in[PIN_DETECT_A] & ~pin_in[PIN_DETECT_B];
        nand_ready_d = pin_in[PIN_WP_READY];
        nand_wp_d = ~pin_in[PIN_LOW_VOLT_WP];
    end

    // Return path registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sd_data_in_q <= 4'h0;
            sd_cmd_in_q <= 1'b0;
            sd_present_q <= 1'b0;
            sd_wp_q <= 1'b0;
            stick_data_in_q <= 4'h0;
            stick_present_q <= 1'b0;
            nand_data_in_q <= 8'h00;
            nand_present_q <= 1'b0;
            nand_ready_q <= 1'b0;
            nand_wp_q <= 1'b0;
        end else begin
            sd_data_in_q <= sd_data_in_d;
            sd_cmd_in_q <= sd_cmd_in_d;
            sd_present_q <= sd_present_d;
            sd_wp_q <= sd_wp_d;
            stick_data_in_q <= stick_data_in_d;
            stick_present_q <= stick_present_d;
            nand_data_in_q <= nand_data_in_d;
            nand_present_q <= nand_present_d;
            nand_ready_q <= nand_ready_d;
            nand_wp_q <= nand_wp_d;
        end
    end

    // Outputs.
    assign mode_active = mode_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;
    assign sd_data_in = sd_data_in_q;
    assign sd_cmd_in = sd_cmd_in_q;
    assign sd_card_present = sd_present_q;
    assign sd_write_protected = sd_wp_q;
    assign stick_data_in = stick_data_in_q;
    assign stick_card_present = stick_present_q;
    assign nand_data_in = nand_data_in_q;
    assign nand_card_present = nand_present_q;
    assign nand_ready = nand_ready_q;
    assign nand_write_protected = nand_wp_q;

    // Checks on the pin drive and the return path.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    mode_through_idle_a: assert property (
        (mode_q != SMP_MODE_NONE) && (mode_d != mode_q) |-> (mode_d == SMP_MODE_NONE))
        else $error("Card type changed without a released cycle.");

    idle_released_a: assert property (
        $past(mode_q) == SMP_MODE_NONE |-> pin_oe_n_q == PIN_OE_N_RESET)
        else $error("A pin was driven while no card type was selected.");

    inputs_never_driven_a: assert property (
        pin_oe_n_q[PIN_DETECT_A] && pin_oe_n_q[PIN_DETECT_B] && pin_oe_n_q[PIN_WP_READY] &&
        pin_oe_n_q[PIN_EXT_CLOCK])
        else $error("A detect, ready or external clock pin was driven.");

    sd_low_volt_off_a: assert property (
        $past(mode_q) == SMP_MODE_SD |-> pin_oe_n_q[PIN_LOW_VOLT_WP])
        else $error("Low-voltage supply pin driven in SD mode.");

    sd_clock_pin_a: assert property (
        mode_q == SMP_MODE_SD |=> !pin_oe_n_q[PIN_CLOCK_READ] && (pin_out_q[PIN_CLOCK_READ] == $past(sd_clk)))
        else $error("SD clock not on pin 09.");

    stick_ext_clock_a: assert property (
        (mode_q == SMP_MODE_STICK) && stick_ext_clk_sel |=> pin_out_q[PIN_CLOCK_READ] == $past(pin_in[PIN_EXT_CLOCK]))
        else $error("Stick clock does not follow the external clock pin.");

    stick_narrow_bus_a: assert property (
        (mode_q == SMP_MODE_STICK) && !stick_wide |=> pin_oe_n_q[PIN_DATA_LO + 3 -: 3] == 3'h7)
        else $error("Stick data bits 1 to 3 driven in one-bit operation.");

    nand_strobes_a: assert property (
        mode_q == SMP_MODE_NAND |=> (pin_out_q[PIN_CMD_STROBE] == $past(nand_write_strobe_n)) &&
        (pin_out_q[PIN_CHIP_ENABLE] == $past(nand_chip_enable_n)) && !pin_oe_n_q[PIN_CHIP_ENABLE])
        else $error("NAND strobes not on pins 08 and 02.");

    nand_bus_drive_a: assert property (
        (mode_q == SMP_MODE_NAND) && nand_data_oe |=> (pin_oe_n_q[17:10] == 8'h00) &&
        (pin_out_q[17:10] == $past(nand_data_out)))
        else $error("NAND data bus not driven on pins 10 to 17.");

    nand_presence_a: assert property (
        $past(rst_n) |-> nand_present_q == ($past(~pin_in[PIN_DETECT_A]) && $past(~pin_in[PIN_DETECT_B])))
        else $error("NAND presence does not need both detect pins low.");

    activity_led_a: assert property (
        (mode_q == SMP_MODE_STICK) && stick_active |=> !pin_out_q[PIN_LED] && !pin_oe_n_q[PIN_LED])
        else $error("Activity indicator not lit for an active stick card.");

    sd_data_drive_a: assert property (
        (mode_q == SMP_MODE_SD) && sd_data_oe |=> (pin_oe_n_q[13:10] == 4'h0) &&
        (pin_out_q[13:10] == $past(sd_data_out)))
        else $error("SD data not driven on pins 10 to 13.");

    sd_cmd_drive_a: assert property (
        mode_q == SMP_MODE_SD |=> (pin_oe_n_q[PIN_CMD_STROBE] == ~$past(sd_cmd_oe)) &&
        (pin_out_q[PIN_CMD_STROBE] == $past(sd_cmd_out)))
        else $error("SD command line not on pin 08.");

    sd_supply_a: assert property (
        mode_q == SMP_MODE_SD |=> !pin_oe_n_q[PIN_SUPPLY] && (pin_out_q[PIN_SUPPLY] == $past(sd_supply_on)))
        else $error("SD supply control not on pin 04.");

    sd_led_a: assert property (
        mode_q == SMP_MODE_SD |=> !pin_oe_n_q[PIN_LED] && (pin_out_q[PIN_LED] == ~$past(sd_active)))
        else $error("SD activity indicator not on pin 06.");

    // Sensed levels are only compared once the registers have left reset, so a card inserted early is no false alarm.
    sd_sense_a: assert property (
        $past(rst_n) |-> (sd_present_q == $past(~pin_in[PIN_DETECT_A])) &&
        (sd_wp_q == $past(~pin_in[PIN_WP_READY])))
        else $error("SD detect or write protect not sensed from pins 00 and 03.");

    stick_bit0_a: assert property (
        (mode_q == SMP_MODE_STICK) && stick_data_oe |=> !pin_oe_n_q[PIN_DATA_LO] &&
        (pin_out_q[PIN_DATA_LO] == $past(stick_data_out[0])))
        else $error("Stick data bit 0 not driven on pin 10.");

    stick_bus_state_a: assert property (
        mode_q == SMP_MODE_STICK |=> !pin_oe_n_q[PIN_CMD_STROBE] &&
        (pin_out_q[PIN_CMD_STROBE] == $past(stick_bus_state)))
        else $error("Stick bus state not on pin 08.");

    stick_int_clock_a: assert property (
        (mode_q == SMP_MODE_STICK) && !stick_ext_clk_sel |=> !pin_oe_n_q[PIN_CLOCK_READ] &&
        (pin_out_q[PIN_CLOCK_READ] == $past(stick_clk)))
        else $error("Stick internal clock not on pin 09.");

    stick_detect_a: assert property (
        $past(rst_n) |-> stick_present_q == $past(~pin_in[PIN_DETECT_B]))
        else $error("Stick detect not sensed low-active on pin 01.");

    nand_latches_a: assert property (
        mode_q == SMP_MODE_NAND |=> (pin_oe_n_q[19:18] == 2'h0) &&
        (pin_out_q[PIN_CMD_LATCH] == $past(nand_cmd_latch)) && (pin_out_q[PIN_ADDR_LATCH] == $past(nand_addr_latch)))
        else $error("NAND latch enables not on pins 18 and 19.");

    nand_read_strobe_a: assert property (
        mode_q == SMP_MODE_NAND |=> !pin_oe_n_q[PIN_CLOCK_READ] &&
        (pin_out_q[PIN_CLOCK_READ] == $past(nand_read_strobe_n)))
        else $error("NAND read strobe not on pin 09.");

    nand_ready_sense_a: assert property (
        $past(rst_n) |-> nand_ready_q == $past(pin_in[PIN_WP_READY]))
        else $error("NAND ready does not follow pin 03.");

    nand_wp_sense_a: assert property (
        $past(rst_n) |-> nand_wp_q == $past(~pin_in[PIN_LOW_VOLT_WP]))
        else $error("NAND write protect not sensed from pin 05.");

    nand_data_return_a: assert property (
        ($past(mode_q) == SMP_MODE_NAND) |-> nand_data_in_q == $past(pin_in[17:10]))
        else $error("NAND data bus not read from pins 10 to 17.");

    unselected_quiet_a: assert property (
        ($past(mode_q) != SMP_MODE_SD) |-> (sd_data_in_q == 4'h0) && !sd_cmd_in_q)
        else $error("SD return path not idle while another card type owns the pins.");

endmodule

//--- hdl/smp_pkg.sv
package smp_pkg;

    // Shared pin bank size and the role of each pin position.
    localparam int unsigned PIN_COUNT = 20;
    localparam int unsigned PIN_DETECT_A = 0;
    localparam int unsigned PIN_DETECT_B = 1;
    localparam int unsigned PIN_CHIP_ENABLE = 2;
    localparam int unsigned PIN_WP_READY = 3;
    localparam int unsigned PIN_SUPPLY = 4;
    localparam int unsigned PIN_LOW_VOLT_WP = 5;
    localparam int unsigned PIN_LED = 6;
    localparam int unsigned PIN_EXT_CLOCK = 7;
    localparam int unsigned PIN_CMD_STROBE = 8;
    localparam int unsigned PIN_CLOCK_READ = 9;
    localparam int unsigned PIN_DATA_LO = 10;
    localparam int unsigned PIN_CMD_LATCH = 18;
    localparam int unsigned PIN_ADDR_LATCH = 19;

    // Data bus widths per card type.
    localparam int unsigned SD_DATA_W = 4;
    localparam int unsigned STICK_DATA_W = 4;
    localparam int unsigned NAND_DATA_W = 8;

    // Values after reset: every pin released, outputs low.
    localparam logic [19:0] PIN_OUT_RESET = 20'h00000;
    localparam logic [19:0] PIN_OE_N_RESET = 20'hFFFFF;

    // Highest external stick clock the socket may present, in MHz.
    localparam int unsigned EXT_CLOCK_MAX_MHZ = 40;
    localparam int unsigned CLK_SYS_MHZ = 20;

    // Card type owning the pins; one-hot.
    typedef enum logic [3:0] {
        SMP_MODE_NONE = 4'h1,
        SMP_MODE_SD = 4'h2,
        SMP_MODE_STICK = 4'h4,
        SMP_MODE_NAND = 4'h8
    } smp_mode_e;

endpackage

//--- test/smp_card_model.sv
`timescale 1ns/10ps
module smp_card_model (
    // Device side of the shared pins
    input wire logic [19:0] pin_out,
    input wire logic [19:0] pin_oe_n,
    // Card contacts and board wiring
    input wire logic detect_a_n,
    input wire logic detect_b_n,
    input wire logic status_pin3,
    input wire logic status_pin5,
    input wire logic ext_clock,
    input wire logic data_drive,
    input wire logic [7:0] data_val,
    // Levels the device senses
    output logic [19:0] pin_in
);
    // Two drivers on one pin give an unknown, so a fighting device cannot pass unseen.
    function automatic logic resolve(input logic oe_n, input logic dev, input logic card_en, input logic card);
        if (!oe_n && card_en) return 1'bx;
        if (!oe_n) return dev;
        return card_en ? card : 1'b1;
    endfunction

    // Released lines float to their board pull-up level.
    always_comb begin
        for (int n = 0; n < 20; n++) pin_in[n] = resolve(pin_oe_n[n], pin_out[n], 1'b0, 1'b0);
        for (int n = 0; n < 8; n++) pin_in[10+n] = resolve(pin_oe_n[10+n], pin_out[10+n], data_drive, data_val[n]);
        pin_in[0] = resolve(pin_oe_n[0], pin_out[0], 1'b1, detect_a_n);
        pin_in[1] = resolve(pin_oe_n[1], pin_out[1], 1'b1, detect_b_n);
        pin_in[3] = resolve(pin_oe_n[3], pin_out[3], 1'b1, status_pin3);
        pin_in[5] = resolve(pin_oe_n[5], pin_out[5], 1'b1, status_pin5);
        pin_in[7] = resolve(pin_oe_n[7], pin_out[7], 1'b1, ext_clock);
    end
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
    import smp_pkg::*;
    // Stimulus starts idle: no card, strobes and the pin 03 and 05 status inputs high, everything else low.
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    smp_mode_e mode_req = SMP_MODE_NONE;
    smp_mode_e mode_active;
    logic [19:0] pin_in, pin_out, pin_oe_n;
    logic [3:0] sd_data_out = 4'h0, stick_data_out = 4'h0, sd_data_in, stick_data_in;
    logic [7:0] nand_data_out = 8'h00, card_data = 8'h00, nand_data_in;
    logic sd_data_oe = 0, sd_cmd_out = 0, sd_cmd_oe = 0, sd_clk = 0, sd_supply_on = 0, sd_active = 0;
    logic stick_data_oe = 0, stick_wide = 0, stick_bus_state = 0, stick_clk = 0, stick_ext_clk_sel = 0;
    logic stick_supply_on = 0, stick_active = 0, nand_data_oe = 0, nand_cmd_latch = 0, nand_addr_latch = 0;
    logic nand_write_strobe_n = 1, nand_read_strobe_n = 1, nand_chip_enable_n = 1, nand_supply_on = 0;
    logic nand_active = 0, det_a_n = 1, det_b_n = 1, stat3 = 1, stat5 = 1, ext_clk = 0, card_drive = 0;
    logic sd_cmd_in, sd_card_present, sd_write_protected, stick_card_present;
    logic nand_card_present, nand_ready, nand_write_protected;
    int compares = 0;
    int miscompares = 0;

    always #25 clk_sys = ~clk_sys;

    smp_pin_mux u_dut (.clk_sys, .rst_n, .mode_req, .mode_active, .pin_in, .pin_out, .pin_oe_n,
        .sd_data_out, .sd_data_oe, .sd_data_in, .sd_cmd_out, .sd_cmd_oe, .sd_cmd_in, .sd_clk, .sd_supply_on,
        .sd_active, .sd_card_present, .sd_write_protected, .stick_data_out, .stick_data_oe, .stick_wide,
        .stick_data_in, .stick_bus_state, .stick_clk, .stick_ext_clk_sel, .stick_supply_on, .stick_active,
        .stick_card_present, .nand_data_out, .nand_data_oe, .nand_data_in, .nand_cmd_latch, .nand_addr_latch,
        .nand_write_strobe_n, .nand_read_strobe_n, .nand_chip_enable_n, .nand_supply_on, .nand_active,
        .nand_card_present, .nand_ready, .nand_write_protected);

    smp_card_model u_card (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .detect_a_n(det_a_n), .detect_b_n(det_b_n),
        .status_pin3(stat3), .status_pin5(stat5), .ext_clock(ext_clk), .data_drive(card_drive),
        .data_val(card_data), .pin_in(pin_in));

    // Inputs always move 5 ns after the edge so the design never races the bench.
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic chk_vec(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input smp_mode_e exp);
        compares++;
        if (mode_active !== exp) begin
            miscompares++;
            $display("ERROR mode_active expected %h seen %h", exp, mode_active);
        end
    endtask

    // A change of owner must pass through a cycle with every pin released.
    task automatic set_mode(input smp_mode_e m);
        logic saw;
        saw = 1'b0;
        mode_req = m;
        repeat (5) begin
            step(1);
            if (pin_oe_n === 20'hFFFFF) saw = 1'b1;
        end
        chk_mode(m);
        chk_vec("released gap", 20'h00001, {19'h00000, saw});
    endtask

    task automatic t_sd();
        set_mode(SMP_MODE_SD);
        {sd_data_out, sd_data_oe, sd_cmd_out, sd_cmd_oe, sd_clk, sd_supply_on, sd_active} = 10'h2BF;
        ext_clk = 1'b1;
        step(1);
        chk_vec("sd oe", 20'hFC0AF, pin_oe_n);
        chk_vec("sd out", 20'h02B10, pin_out & 20'h03F50);
        // The card only drives once the device has let go of the data lines, so the two never fight.
        {sd_data_oe, sd_cmd_oe, sd_active, card_data, ext_clk} = {3'h0, 8'hC5, 1'h0};
        step(1);
        card_drive = 1'b1;
        step(1);
        chk_vec("sd data in", 20'h00005, {16'h0000, sd_data_in});
        chk_vec("sd cmd in led", 20'h00003, {18'h00000, sd_cmd_in, pin_out[6]});
        chk_vec("sd clock pin", 20'h00001, {19'h0, pin_out[9]});
        {det_a_n, stat3} = 2'b00;
        step(1);
        chk_vec("sd detect wp", 20'h00006, {17'h0, sd_card_present, sd_write_protected, stick_card_present});
        {card_drive, det_a_n, stat3, sd_supply_on} = 4'h6;
        $display("test sd done");
    endtask

    task automatic t_stick();
        set_mode(SMP_MODE_STICK);
        {stick_data_out, stick_data_oe, stick_wide, stick_bus_state, stick_clk} = 8'hFB;
        {stick_ext_clk_sel, stick_supply_on, stick_active} = 3'b011;
        step(1);
        chk_vec("stick narrow oe", 20'hFF8AF, pin_oe_n);
        chk_vec("stick narrow out", 20'h00710, pin_out & 20'h00750);
        stick_wide = 1'b1;
        step(1);
        chk_vec("stick wide oe", 20'hFC0AF, pin_oe_n);
        chk_vec("stick wide out", 20'h03F10, pin_out & 20'h03F50);
        {stick_ext_clk_sel, stick_clk, ext_clk} = 3'b101;
        step(3);
        chk_vec("stick ext clock high", 20'h00001, {19'h0, pin_out[9]});
        ext_clk = 1'b0;
        step(3);
        chk_vec("stick ext clock low", 20'h00000, {19'h0, pin_out[9]});
        {stick_data_oe, card_data, det_b_n} = {1'h0, 8'h3A, 1'h0};
        step(1);
        card_drive = 1'b1;
        step(1);
        chk_vec("stick data in", 20'h0000A, {16'h0000, stick_data_in});
        chk_vec("stick detect", 20'h00002, {18'h0, stick_card_present, sd_card_present});
        chk_vec("sd gated", 20'h00000, {16'h0000, sd_data_in});
        {card_drive, det_b_n, stick_supply_on, stick_active} = 4'h4;
        $display("test stick done");
    endtask

    task automatic t_nand();
        set_mode(SMP_MODE_NAND);
        {nand_data_out, nand_data_oe, nand_cmd_latch, nand_addr_latch} = 11'h4B6;
        {nand_write_strobe_n, nand_read_strobe_n, nand_chip_enable_n, nand_supply_on, nand_active} = 5'h0B;
        step(1);
        chk_vec("nand oe", 20'h000AB, pin_oe_n);
        chk_vec("nand out a", 20'h65A10, pin_out & 20'hFFF54);
        {nand_cmd_latch, nand_addr_latch, nand_write_strobe_n, nand_read_strobe_n} = 4'h6;
        {nand_chip_enable_n, nand_active} = 2'b10;
        step(1);
        chk_vec("nand out b", 20'hA5954, pin_out & 20'hFFF54);
        {nand_data_oe, card_data, det_a_n, stat3, stat5} = {1'h0, 8'h5C, 3'h0};
        step(1);
        card_drive = 1'b1;
        step(1);
        chk_vec("nand data in", 20'h0005C, {12'h000, nand_data_in});
        chk_vec("nand one detect", 20'h00001, {17'h0, nand_card_present, nand_ready, nand_write_protected});
        {det_b_n, stat3, stat5} = 3'b011;
        step(1);
        chk_vec("nand present ready", 20'h00006, {17'h0, nand_card_present, nand_ready, nand_write_protected});
        $display("test nand done");
    endtask

    task automatic t_invalid();
        card_drive = 1'b0;
        mode_req = smp_mode_e'(4'h3);
        step(4);
        chk_mode(SMP_MODE_NONE);
        chk_vec("released", 20'hFFFFF, pin_oe_n);
        $display("test invalid done");
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reset for six cycles and check that every pin is released meanwhile.
    initial begin
        step(6);
        chk_mode(SMP_MODE_NONE);
        chk_vec("reset oe", 20'hFFFFF, pin_oe_n);
        chk_vec("reset out", 20'h00000, pin_out);
        rst_n = 1'b1;
        step(1);
        t_sd();
        t_stick();
        t_nand();
        t_invalid();
        conclude();
    end

    // The tests take about 45 cycles; this cuts a hang well beyond that.
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule
